/* design/rcvm_pkg.sv */
// package: register map, field positions and reset values of the monitor
package rcvm_pkg;
  localparam int ADDR_W = 10;
  // register offsets, one aligned 32-bit word per register
  localparam logic [9:0] OFF_PROTECT   = 10'h00a; // not a multiple of four
  localparam logic [9:0] OFF_CAUSE     = 10'h018;
  localparam logic [9:0] OFF_VSTATUS   = 10'h019;
  localparam logic [9:0] OFF_VENABLE   = 10'h01a;
  localparam logic [9:0] OFF_VFUNC     = 10'h026;
  localparam logic [9:0] OFF_V2LEVEL   = 10'h028;
  localparam logic [9:0] OFF_MON0      = 10'h02a;
  localparam logic [9:0] OFF_MON2      = 10'h02c;
  localparam logic [9:0] OFF_IRQ_STAT  = 10'h030;
  localparam logic [9:0] OFF_IRQ_EN    = 10'h031;
  localparam logic [9:0] OFF_IRQ_CLR   = 10'h032;
  localparam logic [9:0] OFF_GUARD_WR  = 10'h033;
  // protect bit positions
  localparam int PR_CLOCK = 0;
  localparam int PR_PORT  = 2;
  localparam int PR_VMON  = 3;
  localparam int PR_PMODE = 6;
  localparam logic [7:0] PROTECT_MASK = 8'h4d;
  // reset cause bit positions
  localparam int RC_HW   = 1;
  localparam int RC_SW   = 2;
  localparam int RC_WDT  = 3;
  localparam int RC_VM2  = 5;
  localparam int RC_OSC  = 6;
  localparam logic [7:0] CAUSE_MASK = 8'h6e;
  // voltage control bit positions
  localparam int VS_LOW  = 3;
  localparam int VE_DET0 = 5;
  localparam int VE_DET2 = 7;
  localparam logic [7:0] VENABLE_MASK = 8'ha0;
  // interrupt status bits
  localparam int IRQ_LOW2 = 0;
  localparam int IRQ_BLOCKED = 1;
  localparam int IRQ_W = 2;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // guarded register groups named by write_protect_control
  typedef enum logic [1:0] {
    RCVM_GRP_CLOCK = 2'h0,
    RCVM_GRP_PORT  = 2'h1,
    RCVM_GRP_VMON  = 2'h2,
    RCVM_GRP_PMODE = 2'h3
  } rcvm_grp_t;
endpackage : rcvm_pkg

/* design/rcvm_top.sv */
// reset cause recorder, voltage detector control and write protection
module rcvm_top
  import rcvm_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  // avalon-mm slave
  input  wire logic [rcvm_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  output logic      [1:0]                avs_response,
  // reset cause inputs, latched into the flags when they pulse; power_on_seen clears the flags instead
  input  wire logic                      pin_reset_seen,
  input  wire logic                      sw_reset_req,
  input  wire logic                      wdt_reset_req,
  input  wire logic                      osc_stop_req,
  input  wire logic                      power_on_seen,
  // analog comparator outputs, asynchronous to clk
  input  wire logic                      below_second_level,
  input  wire logic                      below_zeroth_level,
  // guarded register write port to the rest of the chip
  input  wire logic [1:0]                guard_group_sel,
  output logic                           guard_wr_pulse,
  output logic      [1:0]                guard_wr_group,
  output logic      [7:0]                guard_wr_data,
  // detector controls and reset requests
  output logic                           det0_enable,
  output logic                           det2_enable,
  output logic                           chip_reset_req,
  output logic                           irq
);
  import rcvm_pkg::*;

  logic [7:0]          protect_q;
  logic [7:0]          cause_q;
  logic [7:0]          venable_q;
  logic [7:0]          vfunc_q;
  logic [7:0]          v2level_q;
  logic [7:0]          mon0_q;
  logic [7:0]          mon2_q;
  logic [IRQ_W-1:0]    irq_stat_q;
  logic [IRQ_W-1:0]    irq_en_q;
  logic                low2_meta_q;
  logic                low2_sync_q;
  logic                low0_meta_q;
  logic                low0_sync_q;
  logic                vm2_rst_q;
  logic                vm0_rst_q;
  logic                low_flag_q;
  logic                low_flag_prev_q;
  // bus handshake, decoded strobes and interrupt events
  logic                ack_q;
  logic                access;
  logic                wr_hit;
  logic [7:0]          wbyte;
  logic                guard_ok;
  logic                blocked_ev;
  logic                low_fall_ev;
  logic [IRQ_W-1:0]    irq_set;
  logic [IRQ_W-1:0]    irq_clr;
  logic                guard_hit;
  logic                vmon_open;
  logic [7:0]          cause_d;
  logic [7:0]          rd_byte;
  logic                rd_err;

  // decode of one register offset against the bus address
  function automatic logic hit(input logic [9:0] off,
                               input logic [9:0] adr);
    hit = (adr == off);
  endfunction : hit

  // protect bit that opens a given guarded group
  function automatic logic group_open(input logic [1:0] g,
                                      input logic [7:0] p);
    case (rcvm_grp_t'(g))
      RCVM_GRP_CLOCK: group_open = p[PR_CLOCK];
      RCVM_GRP_PORT:  group_open = p[PR_PORT];
      RCVM_GRP_VMON:  group_open = p[PR_VMON];
      RCVM_GRP_PMODE: group_open = p[PR_PMODE];
      default:        group_open = 1'b0;
    endcase
  endfunction : group_open

  // byte offsets address words: printed offsets are word indices
  // a write acts only on the edge where the master sees waitrequest
  // low, so a write held through the wait state lands exactly once
  assign access = (avs_read | avs_write) & ~ack_q;
  assign wr_hit = avs_write & ack_q & avs_byteenable[0];
  assign wbyte  = avs_writedata[7:0];

  // one wait state: the request is answered on the second edge
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end

  // waitrequest idles high; low for the one answer cycle only
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~access;
    end
  end

  // second level comparator: two flops, only the second one is read
  always_ff @(posedge clk) begin
    if (rst) begin
      low2_meta_q <= 1'b0;
      low2_sync_q <= 1'b0;
    end else begin
      low2_meta_q <= below_second_level;
      low2_sync_q <= low2_meta_q;
    end
  end

  // zeroth level comparator: same two-flop path
  always_ff @(posedge clk) begin
    if (rst) begin
      low0_meta_q <= 1'b0;
      low0_sync_q <= 1'b0;
    end else begin
      low0_meta_q <= below_zeroth_level;
      low0_sync_q <= low0_meta_q;
    end
  end

  // protect register: only documented bits are writable
  always_ff @(posedge clk) begin
    if (rst) begin
      protect_q <= RST_BYTE;
    end else if (wr_hit && hit(OFF_PROTECT, avs_address)) begin
      protect_q <= wbyte & PROTECT_MASK;
    end
  end

  // monitor configuration, every byte guarded by protect bit 3
  assign vmon_open = wr_hit && protect_q[PR_VMON];

  // enable register: reserved bits stay zero
  always_ff @(posedge clk) begin
    if (rst) begin
      venable_q <= RST_BYTE;
    end else if (vmon_open && hit(OFF_VENABLE, avs_address)) begin
      venable_q <= wbyte & VENABLE_MASK;
    end
  end

  // monitor function enable byte
  always_ff @(posedge clk) begin
    if (rst) begin
      vfunc_q <= RST_BYTE;
    end else if (vmon_open && hit(OFF_VFUNC, avs_address)) begin
      vfunc_q <= wbyte;
    end
  end

  // detector two level select byte
  always_ff @(posedge clk) begin
    if (rst) begin
      v2level_q <= RST_BYTE;
    end else if (vmon_open && hit(OFF_V2LEVEL, avs_address)) begin
      v2level_q <= wbyte;
    end
  end

  // monitor zero control; bit 0 arms its reset
  always_ff @(posedge clk) begin
    if (rst) begin
      mon0_q <= RST_BYTE;
    end else if (vmon_open && hit(OFF_MON0, avs_address)) begin
      mon0_q <= wbyte;
    end
  end

  // monitor two control; bit 0 arms its reset
  always_ff @(posedge clk) begin
    if (rst) begin
      mon2_q <= RST_BYTE;
    end else if (vmon_open && hit(OFF_MON2, avs_address)) begin
      mon2_q <= wbyte;
    end
  end

  // detector zero enable straight from the enable register
  always_ff @(posedge clk) begin
    if (rst) begin
      det0_enable <= 1'b0;
    end else begin
      det0_enable <= venable_q[VE_DET0];
    end
  end

  // detector two enable straight from the enable register
  always_ff @(posedge clk) begin
    if (rst) begin
      det2_enable <= 1'b0;
    end else begin
      det2_enable <= venable_q[VE_DET2];
    end
  end

  // low voltage flag reads 1 when detector two is off
  always_ff @(posedge clk) begin
    if (rst) begin
      low_flag_q      <= 1'b1;
      low_flag_prev_q <= 1'b1;
    end else begin
      low_flag_q      <= ~(venable_q[VE_DET2] & low2_sync_q);
      low_flag_prev_q <= low_flag_q;
    end
  end

  // monitor two reset: needs its detector on and its arm bit set
  always_ff @(posedge clk) begin
    if (rst) begin
      vm2_rst_q <= 1'b0;
    end else begin
      vm2_rst_q <= venable_q[VE_DET2] & mon2_q[0] & low2_sync_q;
    end
  end

  // monitor zero reset: armed the same way by its own control
  always_ff @(posedge clk) begin
    if (rst) begin
      vm0_rst_q <= 1'b0;
    end else begin
      vm0_rst_q <= venable_q[VE_DET0] & mon0_q[0] & low0_sync_q;
    end
  end

  // either monitor reset (two or zero) asks the reset controller for a chip reset
  always_ff @(posedge clk) begin
    if (rst) begin
      chip_reset_req <= 1'b0;
    end else begin
      chip_reset_req <= vm2_rst_q | vm0_rst_q;
    end
  end

  // next cause value: power-on clears, then a fixed source priority
  always_comb begin
    cause_d = cause_q;
    if (power_on_seen) begin
      cause_d = RST_BYTE;
    end else if (pin_reset_seen) begin
      cause_d = 8'h02;
    end else if (sw_reset_req) begin
      cause_d = 8'h04;
    end else if (wdt_reset_req) begin
      cause_d = 8'h08;
    end else if (vm2_rst_q) begin
      cause_d = 8'h20;
    end else if (osc_stop_req) begin
      cause_d = 8'h40;
    end else if (vm0_rst_q) begin
      cause_d = RST_BYTE;
    end
  end

  // cause flags survive rst; the last source seen wins
  // rst itself is the chip reset, so flags use their own clear
  always_ff @(posedge clk) begin
    cause_q <= cause_d;
  end

  // guarded writes for registers that live elsewhere in the chip
  assign guard_hit  = wr_hit && hit(OFF_GUARD_WR, avs_address);
  assign guard_ok = group_open(guard_group_sel, protect_q);
  assign blocked_ev = guard_hit && !guard_ok;
  always_ff @(posedge clk) begin
    if (rst) begin
      guard_wr_pulse <= 1'b0;
      guard_wr_group <= 2'h0;
      guard_wr_data  <= RST_BYTE;
    end else begin
      guard_wr_pulse <= guard_hit && guard_ok;
      if (guard_hit) begin
        guard_wr_group <= guard_group_sel;
        guard_wr_data  <= wbyte;
      end
    end
  end

  // interrupt status: set wins over a clear in the same cycle
  assign low_fall_ev = low_flag_prev_q & ~low_flag_q;
  assign irq_set = {blocked_ev, low_fall_ev};
  assign irq_clr = (wr_hit && hit(OFF_IRQ_CLR, avs_address))
                   ? wbyte[IRQ_W-1:0] : '0;
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  // interrupt enables, same layout as the status bits
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_en_q <= '0;
    end else if (wr_hit && hit(OFF_IRQ_EN, avs_address)) begin
      irq_en_q <= wbyte[IRQ_W-1:0];
    end
  end

  // level interrupt, high while an enabled status bit is set
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // read mux: one byte per register, unmapped offsets flag an error
  always_comb begin
    rd_byte = RST_BYTE;
    rd_err  = 1'b0;
    case (avs_address)
      OFF_PROTECT:  rd_byte = protect_q;
      OFF_CAUSE:    rd_byte = cause_q & CAUSE_MASK;
      OFF_VSTATUS:  rd_byte = {4'h0, low_flag_q, 3'h0};
      OFF_VENABLE:  rd_byte = venable_q;
      OFF_VFUNC:    rd_byte = vfunc_q;
      OFF_V2LEVEL:  rd_byte = v2level_q;
      OFF_MON0:     rd_byte = mon0_q;
      OFF_MON2:     rd_byte = mon2_q;
      OFF_IRQ_STAT: rd_byte = {{(8-IRQ_W){1'b0}}, irq_stat_q};
      OFF_IRQ_EN:   rd_byte = {{(8-IRQ_W){1'b0}}, irq_en_q};
      OFF_IRQ_CLR:  rd_byte = RST_BYTE; // write-only, reads zero
      OFF_GUARD_WR: rd_byte = RST_BYTE;
      default:      rd_err  = 1'b1;
    endcase
  end

  // read data and response, registered with the answer
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end else if (access) begin
      avs_readdata <= {24'h00_0000, rd_byte};
      avs_response <= rd_err ? 2'b10 : 2'b00; // slave error on a miss
    end
  end
endmodule : rcvm_top

/* verification/rcvm_sva.sv */
// checker: bus answer, guarded write and detector output properties
module rcvm_sva
  import rcvm_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic [rcvm_pkg::ADDR_W-1:0] avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [31:0]                 avs_readdata,
  input wire logic                        avs_waitrequest,
  input wire logic [1:0]                  avs_response,
  input wire logic                        guard_wr_pulse,
  input wire logic                        det0_enable,
  input wire logic                        det2_enable,
  input wire logic                        chip_reset_req,
  input wire logic                        irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // decodes, so that output changes can be traced to their write
  logic req, ven_wr, grd_wr;
  assign req    = avs_read || avs_write;
  assign ven_wr = avs_write && avs_address == OFF_VENABLE;
  assign grd_wr = avs_write && avs_address == OFF_GUARD_WR;

  a_wait_bound: assert property (req && avs_waitrequest
    |-> ##[1:2] !avs_waitrequest) else $error("request not answered");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  a_answer_needs_req: assert property (!avs_waitrequest |-> req)
    else $error("answer without request");
  a_read_upper_zero: assert property (!avs_waitrequest
    |-> avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  a_cause_resp_ok: assert property (!avs_waitrequest
    && avs_address == OFF_CAUSE |-> avs_response == 2'b00)
    else $error("mapped read flagged");
  a_det_from_write: assert property ($changed(det0_enable)
    || $changed(det2_enable) |-> $past(ven_wr) || $past(ven_wr, 2))
    else $error("detector enable moved without write");
  a_guard_from_write: assert property (guard_wr_pulse
    |-> $past(grd_wr) || $past(grd_wr, 2)) else $error("stray guard pulse");
  a_guard_one_pulse: assert property (guard_wr_pulse |=> !guard_wr_pulse)
    else $error("guard pulse too long");
  a_reset_armed: assert property (chip_reset_req
    |-> det0_enable || det2_enable) else $error("reset with no detector");
  a_irq_fall_write: assert property ($fell(irq) |-> $past(avs_write)
    || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("irq dropped without write");

  c_guard: cover property ($rose(guard_wr_pulse));
  c_chip_reset: cover property ($rose(chip_reset_req));
  c_irq: cover property ($rose(irq));
endmodule : rcvm_sva

bind rcvm_top rcvm_sva u_sva (.clk, .rst, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .avs_response,
  .guard_wr_pulse, .det0_enable, .det2_enable, .chip_reset_req, .irq);

/* verification/tb_top.sv */
// testbench: register bus scenarios for the reset cause and voltage monitor
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rcvm_pkg::*;
  logic              clk, rst, avs_read, avs_write, power_on_seen;
  logic              pin_reset_seen, sw_reset_req, wdt_reset_req;
  logic              osc_stop_req, below_second_level, below_zeroth_level;
  logic              guard_wr_pulse, det0_enable, det2_enable;
  logic              chip_reset_req, irq, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0]       avs_writedata, avs_readdata;
  logic [3:0]        avs_byteenable, src;
  logic [1:0]        avs_response, guard_group_sel, guard_wr_group, rsp, g_grp;
  logic [7:0]        guard_wr_data, q, g_dat;
  int                fail_count = 0, total_checks = 0, g_cnt = 0;
  int                cbit [4] = '{RC_HW, RC_SW, RC_WDT, RC_OSC};
  int                pb [4] = '{PR_CLOCK, PR_PORT, PR_VMON, PR_PMODE};
  assign {osc_stop_req, wdt_reset_req, sw_reset_req, pin_reset_seen} = src;

  rcvm_top uut (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .avs_response, .pin_reset_seen, .sw_reset_req, .wdt_reset_req,
    .osc_stop_req, .power_on_seen, .below_second_level, .below_zeroth_level,
    .guard_group_sel, .guard_wr_pulse, .guard_wr_group, .guard_wr_data,
    .det0_enable, .det2_enable, .chip_reset_req, .irq);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // count accepted guarded writes, keep the last one
  always @(posedge clk) begin
    if (guard_wr_pulse === 1'b1) begin
      g_cnt <= g_cnt + 1;
      g_grp <= guard_wr_group;
      g_dat <= guard_wr_data;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    total_checks++;
    if (got !== want) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk

  // one bus cycle, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) chk(8'hee, 8'h00);
    q = avs_readdata[7:0];
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] want,
                    input logic [7:0] m = 8'hff);
    acc(1'b0, a, 8'h00);
    chk(q & m, want);
  endtask : rd

  // let synchronisers and output registers settle
  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic pulse(input logic [3:0] s, input logic p);
    @(posedge clk);
    src <= s;
    power_on_seen <= p;
    @(posedge clk);
    src <= 4'h0;
    power_on_seen <= 1'b0;
  endtask : pulse

  task automatic outs(input logic [7:0] want);
    settle();
    chk({4'h0, irq, chip_reset_req, det2_enable, det0_enable}, want);
  endtask : outs

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (6000) @(posedge clk);
    chk(8'hee, 8'h00);
    complete_run();
  end

  initial begin
    {rst, avs_read, avs_write, avs_address, avs_writedata} = '0;
    rst = 1'b1;
    {src, power_on_seen, below_second_level, below_zeroth_level} = '0;
    avs_byteenable = 4'h1;
    guard_group_sel = 2'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_PROTECT, RST_BYTE);
    rd(OFF_VENABLE, RST_BYTE);
    wr(OFF_PROTECT, 8'hff);
    rd(OFF_PROTECT, PROTECT_MASK);
    acc(1'b0, 10'h3ff, 8'h00);
    chk({6'h0, rsp}, 8'h02);
    $display("registers test done");
    for (int i = 0; i < 4; i++) begin
      pulse(4'h0, 1'b1);
      rd(OFF_CAUSE, 8'h00);
      pulse(4'h1 << i, 1'b0);
      rd(OFF_CAUSE, 8'h01 << cbit[i]);
    end
    $display("cause test done");
    wr(OFF_PROTECT, PROTECT_MASK & ~8'h08);
    wr(OFF_VENABLE, 8'ha0);
    rd(OFF_VENABLE, 8'h00);
    wr(OFF_PROTECT, 8'h08);
    wr(OFF_VENABLE, 8'ha0);
    outs(8'h03);
    rd(OFF_VSTATUS, 8'h08, 8'h08);
    @(posedge clk) below_second_level <= 1'b1;
    settle();
    rd(OFF_VSTATUS, 8'h00, 8'h08);
    rd(OFF_IRQ_STAT, 8'h01);
    wr(OFF_IRQ_EN, 8'h01);
    outs(8'h0b);
    wr(OFF_IRQ_EN, 8'h00);
    wr(OFF_VENABLE, 8'h20);
    outs(8'h01);
    rd(OFF_VSTATUS, 8'h08, 8'h08);
    wr(OFF_IRQ_CLR, 8'h01);
    rd(OFF_IRQ_STAT, 8'h00);
    pulse(4'h0, 1'b1);
    wr(OFF_MON2, 8'h01);
    wr(OFF_VENABLE, 8'ha0);
    outs(8'h07);
    rd(OFF_CAUSE, 8'h20);
    @(posedge clk) below_second_level <= 1'b0;
    wr(OFF_MON0, 8'h01);
    @(posedge clk) below_zeroth_level <= 1'b1;
    outs(8'h07);
    rd(OFF_CAUSE, 8'h00);
    @(posedge clk) below_zeroth_level <= 1'b0;
    $display("voltage test done");
    wr(OFF_IRQ_EN, 8'h02);
    for (int g = 0; g < 4; g++) begin
      @(posedge clk) guard_group_sel <= 2'(g);
      wr(OFF_PROTECT, PROTECT_MASK & ~(8'h01 << pb[g]));
      wr(OFF_GUARD_WR, 8'(8'h50 + g));
      outs(8'h0b);
      chk(g_cnt[7:0], 8'(g));
      wr(OFF_IRQ_CLR, 8'h02);
      wr(OFF_PROTECT, 8'h01 << pb[g]);
      wr(OFF_GUARD_WR, 8'(8'ha0 + g));
      outs(8'h03);
      chk(g_cnt[7:0], 8'(g + 1));
      chk({6'h0, g_grp}, 8'(g));
      chk(g_dat, 8'(8'ha0 + g));
    end
    $display("guard test done");
    complete_run();
  end
endmodule : tb_top
